//--- hdl/mem_decode_pkg.sv
// Constants and types shared by the memory address decoder files
package mem_decode_pkg;

  // ==========================================================================
  // Widths
  localparam int unsigned REG_AW   = 12;
  localparam int unsigned PM_AW    = 16;
  localparam int unsigned DW       = 8;
  localparam int unsigned RAM_AW   = 9;
  localparam int unsigned CTL_AW   = 8;
  localparam int unsigned FLASH_AW = 14;
  localparam int unsigned INFO_AW  = 9;

  // ==========================================================================
  // Register space map
  localparam logic [11:0] RAM_BASE = 12'h000;
  localparam logic [11:0] RAM_LAST = 12'h1ff;
  localparam logic [11:0] CTL_BASE = 12'hf00;
  localparam logic [11:0] TMR_LAST = 12'hf09;
  localparam logic [11:0] GAP_LAST = 12'hf1f;
  localparam logic [11:0] PWM_BASE = 12'hf20;
  localparam logic [11:0] PWM_LAST = 12'hf29;

  // ==========================================================================
  // Program memory map
  localparam logic [15:0] OPT_LAST   = 16'h0001;
  localparam logic [15:0] RVEC_LAST  = 16'h0003;
  localparam logic [15:0] XVEC_LAST  = 16'h0007;
  localparam logic [15:0] IVEC_LAST  = 16'h003f;
  localparam logic [15:0] FLASH_LAST = 16'h3fff;
  localparam logic [15:0] INFO_BASE  = 16'hfe00;
  localparam logic [8:0]  PNUM_OFF   = 9'h040;
  localparam int unsigned PNUM_BYTES = 32;
  localparam int unsigned PNUM_CHARS = 20;
  localparam int unsigned OVL_BIT    = 7;

  // ==========================================================================
  // Data values
  localparam logic [7:0] ERASED    = 8'hff;
  localparam logic [7:0] UNDEF     = 8'h00;
  localparam logic [7:0] PAD       = 8'h00;
  localparam logic [7:0] INFO_RSVD = 8'hff;

  // ==========================================================================
  // Enumerations
  typedef enum logic [1:0] {
    PM_FETCH, PM_PROGRAM_LOAD_CONSTANT_INSTR, PM_PROGRAM_LOAD_CONSTANT_INCR_INSTR, PM_DEBUG
  } pm_kind_e;
  typedef enum logic [2:0] {
    PR_NONE, PR_OPTION, PR_RESET_VEC, PR_EXC_VEC, PR_INT_VEC, PR_CODE
  } pm_region_e;
  typedef enum logic [2:0] {RS_NONE, RS_RAM, RS_TMR, RS_PWM, RS_PERIPH, RS_UNDEF} reg_tgt_e;
  typedef enum logic [1:0] {PS_FLASH, PS_INFO, PS_ERASED} pm_src_e;

endpackage

//--- hdl/info_rom_if.sv
// Lookup path between the decoder and the information area
`timescale 1ns/1ps
interface info_rom_if;
  logic [8:0] offset;
  logic [7:0] data;
  modport requester (output offset, input data);
  modport responder (input offset, output data);
endinterface

//--- hdl/info_area_rom.sv
// Read-only information area with the part identification string
`timescale 1ns/1ps
module info_area_rom #(
  // Arbitrary neutral identification text, left-justified, zero padded
  parameter logic [159:0] PART_ID = {"GENERIC-MOTOR-MCU", 24'h00_0000}
) (
  info_rom_if.responder rom
);

  logic [7:0] pnum [mem_decode_pkg::PNUM_BYTES];

  // ==========================================================================
  // Identification table, characters first then zero fill
  for (genvar g = 0; g < mem_decode_pkg::PNUM_BYTES; g++) begin : g_pnum
    if (g < mem_decode_pkg::PNUM_CHARS) begin : g_chr
      assign pnum[g] = PART_ID[159-8*g -: 8];
    end else begin : g_pad
      assign pnum[g] = mem_decode_pkg::PAD;
    end
  end

  // No write path exists at all, so contents can never change
  always_comb begin
    if (rom.offset[8:5] == mem_decode_pkg::PNUM_OFF[8:5]) begin
      rom.data = pnum[rom.offset[4:0]];
    end else begin
      rom.data = mem_decode_pkg::INFO_RSVD;
    end
  end

endmodule

//--- hdl/memory_address_decoder.sv
// Address decoder for register space, program memory and information area
`timescale 1ns/1ps

// Contract
// - 512 bytes RAM from address zero
// - F00h to FFFh decodes as control registers
// - Unassigned control reads complete, value unspecified
// - 200h to EFFh: undefined reads, writes dropped
// - Source operands read, destination operands written
// - 16KB flash; reads beyond return FFh
// - Writes to unimplemented program memory ignored
// - Options, reset, exception, interrupt vectors, code layout
// - No separate data memory space implemented
// - Page select bit 7 enables the overlay
// - Overlay covers FE00h through FFFFh
// - Load-constant reads return information bytes when overlaid
// - Debugger reads return information bytes when overlaid
// - Instruction fetches always served from flash
// - Information area is read only
// - FE40h-FE5Fh holds left-aligned zero-padded part string
// - F00-F09 timer, F20-F29 PWM, F0A-F1F unassigned
module memory_address_decoder (
  input  wire logic                     i_clk,
  input  wire logic                     i_rst,
  input  wire logic [7:0]               i_page_sel,
  input  wire logic                     i_src_rd,
  input  wire logic [11:0]              i_src_addr,
  input  wire logic                     i_dst_wr,
  input  wire logic [11:0]              i_dst_addr,
  input  wire logic [7:0]               i_dst_wdata,
  output logic                          o_reg_ack,
  output logic [7:0]                    o_reg_rdata,
  output logic                          o_ram_re,
  output logic [8:0]                    o_ram_raddr,
  output logic                          o_ram_we,
  output logic [8:0]                    o_ram_waddr,
  output logic [7:0]                    o_ram_wdata,
  input  wire logic [7:0]               i_ram_rdata,
  output logic                          o_tmr_re,
  output logic                          o_tmr_we,
  output logic                          o_pwm_re,
  output logic                          o_pwm_we,
  output logic                          o_per_re,
  output logic                          o_per_we,
  output logic [7:0]                    o_ctl_raddr,
  output logic [7:0]                    o_ctl_waddr,
  output logic [7:0]                    o_ctl_wdata,
  input  wire logic [7:0]               i_tmr_rdata,
  input  wire logic [7:0]               i_pwm_rdata,
  input  wire logic [7:0]               i_per_rdata,
  input  wire logic                     i_pm_rd,
  input  wire logic                     i_pm_wr,
  input  wire mem_decode_pkg::pm_kind_e i_pm_kind,
  input  wire logic [15:0]              i_pm_addr,
  input  wire logic [7:0]               i_pm_wdata,
  output logic                          o_pm_ack,
  output logic [7:0]                    o_pm_rdata,
  output mem_decode_pkg::pm_region_e    o_pm_region,
  output logic                          o_flash_re,
  output logic                          o_flash_we,
  output logic [13:0]                   o_flash_addr,
  output logic [7:0]                    o_flash_wdata,
  input  wire logic [7:0]               i_flash_rdata,
  input  wire logic                     i_dm_req,
  output logic                          o_dm_ack,
  output logic [7:0]                    o_dm_rdata,
  output logic                          o_ovl_en
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic                       ram_re;
    logic [8:0]                 ram_raddr;
    logic                       ram_we;
    logic [8:0]                 ram_waddr;
    logic [7:0]                 ram_wdata;
    logic                       tmr_re;
    logic                       tmr_we;
    logic                       pwm_re;
    logic                       pwm_we;
    logic                       per_re;
    logic                       per_we;
    logic [7:0]                 ctl_raddr;
    logic [7:0]                 ctl_waddr;
    logic [7:0]                 ctl_wdata;
    mem_decode_pkg::reg_tgt_e   rd_tgt;
    logic                       reg_ack;
    logic [7:0]                 reg_rdata;
    logic                       pm_pend;
    mem_decode_pkg::pm_src_e    pm_src;
    logic [8:0]                 info_off;
    logic                       pm_ack;
    logic [7:0]                 pm_rdata;
    mem_decode_pkg::pm_region_e pm_region;
    logic                       flash_re;
    logic                       flash_we;
    logic [13:0]                flash_addr;
    logic [7:0]                 flash_wdata;
    logic                       dm_ack;
    logic [7:0]                 dm_rdata;
    logic                       ovl_en;
  } state_s;

  state_s state;
  state_s next_state;

  info_rom_if info ();

  info_area_rom u_info (
    .rom (info.responder)
  );

  assign info.offset = state.info_off;

  // ==========================================================================
  // Decode helpers
  function automatic mem_decode_pkg::reg_tgt_e reg_target(input logic [11:0] a);
    if (a <= mem_decode_pkg::RAM_LAST) begin
      reg_target = mem_decode_pkg::RS_RAM;
    end else if (a < mem_decode_pkg::CTL_BASE) begin
      reg_target = mem_decode_pkg::RS_UNDEF;
    end else if (a <= mem_decode_pkg::TMR_LAST) begin
      reg_target = mem_decode_pkg::RS_TMR;
    end else if (a <= mem_decode_pkg::GAP_LAST) begin
      reg_target = mem_decode_pkg::RS_UNDEF;
    end else if (a >= mem_decode_pkg::PWM_BASE && a <= mem_decode_pkg::PWM_LAST) begin
      reg_target = mem_decode_pkg::RS_PWM;
    end else begin
      // Rest of the control page belongs to the other peripherals
      reg_target = mem_decode_pkg::RS_PERIPH;
    end
  endfunction

  function automatic mem_decode_pkg::pm_region_e pm_region(input logic [15:0] a);
    if (a <= mem_decode_pkg::OPT_LAST) begin
      pm_region = mem_decode_pkg::PR_OPTION;
    end else if (a <= mem_decode_pkg::RVEC_LAST) begin
      pm_region = mem_decode_pkg::PR_RESET_VEC;
    end else if (a <= mem_decode_pkg::XVEC_LAST) begin
      pm_region = mem_decode_pkg::PR_EXC_VEC;
    end else if (a <= mem_decode_pkg::IVEC_LAST) begin
      pm_region = mem_decode_pkg::PR_INT_VEC;
    end else if (a <= mem_decode_pkg::FLASH_LAST) begin
      pm_region = mem_decode_pkg::PR_CODE;
    end else begin
      pm_region = mem_decode_pkg::PR_NONE;
    end
  endfunction

  // ==========================================================================
  // Next state
  always_comb begin
    mem_decode_pkg::reg_tgt_e wtgt;
    logic                     ovl_hit;
    wtgt       = mem_decode_pkg::RS_NONE;
    ovl_hit    = 1'b0;
    next_state = state;

    next_state.ram_re   = 1'b0;
    next_state.ram_we   = 1'b0;
    next_state.tmr_re   = 1'b0;
    next_state.tmr_we   = 1'b0;
    next_state.pwm_re   = 1'b0;
    next_state.pwm_we   = 1'b0;
    next_state.per_re   = 1'b0;
    next_state.per_we   = 1'b0;
    next_state.flash_re = 1'b0;
    next_state.flash_we = 1'b0;
    next_state.reg_ack  = 1'b0;
    next_state.pm_ack   = 1'b0;
    next_state.pm_pend  = 1'b0;
    next_state.rd_tgt   = mem_decode_pkg::RS_NONE;
    next_state.ovl_en   = i_page_sel[mem_decode_pkg::OVL_BIT];

    // Register read completes one cycle after the strobe, whatever the target
    case (state.rd_tgt)
      mem_decode_pkg::RS_NONE: begin
        next_state.reg_ack = 1'b0;
      end
      mem_decode_pkg::RS_RAM: begin
        next_state.reg_ack   = 1'b1;
        next_state.reg_rdata = i_ram_rdata;
      end
      mem_decode_pkg::RS_TMR: begin
        next_state.reg_ack   = 1'b1;
        next_state.reg_rdata = i_tmr_rdata;
      end
      mem_decode_pkg::RS_PWM: begin
        next_state.reg_ack   = 1'b1;
        next_state.reg_rdata = i_pwm_rdata;
      end
      mem_decode_pkg::RS_PERIPH: begin
        next_state.reg_ack   = 1'b1;
        next_state.reg_rdata = i_per_rdata;
      end
      default: begin
        // No error path: holes simply answer with a filler byte
        next_state.reg_ack   = 1'b1;
        next_state.reg_rdata = mem_decode_pkg::UNDEF;
      end
    endcase

    // Source operand read
    if (i_src_rd) begin
      next_state.rd_tgt = reg_target(i_src_addr);
      case (next_state.rd_tgt)
        mem_decode_pkg::RS_RAM: begin
          next_state.ram_re    = 1'b1;
          next_state.ram_raddr = i_src_addr[8:0];
        end
        mem_decode_pkg::RS_TMR: begin
          next_state.tmr_re    = 1'b1;
          next_state.ctl_raddr = i_src_addr[7:0];
        end
        mem_decode_pkg::RS_PWM: begin
          next_state.pwm_re    = 1'b1;
          next_state.ctl_raddr = i_src_addr[7:0];
        end
        mem_decode_pkg::RS_PERIPH: begin
          next_state.per_re    = 1'b1;
          next_state.ctl_raddr = i_src_addr[7:0];
        end
        default: begin
          // Holes still present their low byte, only the strobe is withheld
          next_state.ctl_raddr = i_src_addr[7:0];
        end
      endcase
    end

    // Destination operand write; holes swallow the write
    if (i_dst_wr) begin
      wtgt = reg_target(i_dst_addr);
      case (wtgt)
        mem_decode_pkg::RS_RAM: begin
          next_state.ram_we    = 1'b1;
          next_state.ram_waddr = i_dst_addr[8:0];
          next_state.ram_wdata = i_dst_wdata;
        end
        mem_decode_pkg::RS_TMR: begin
          next_state.tmr_we    = 1'b1;
          next_state.ctl_waddr = i_dst_addr[7:0];
          next_state.ctl_wdata = i_dst_wdata;
        end
        mem_decode_pkg::RS_PWM: begin
          next_state.pwm_we    = 1'b1;
          next_state.ctl_waddr = i_dst_addr[7:0];
          next_state.ctl_wdata = i_dst_wdata;
        end
        mem_decode_pkg::RS_PERIPH: begin
          next_state.per_we    = 1'b1;
          next_state.ctl_waddr = i_dst_addr[7:0];
          next_state.ctl_wdata = i_dst_wdata;
        end
        default: begin
          next_state.ram_we = 1'b0;
        end
      endcase
    end

    // Program memory answer
    if (state.pm_pend) begin
      next_state.pm_ack = 1'b1;
      case (state.pm_src)
        mem_decode_pkg::PS_FLASH:  next_state.pm_rdata = i_flash_rdata;
        mem_decode_pkg::PS_INFO:   next_state.pm_rdata = info.data;
        default:                   next_state.pm_rdata = mem_decode_pkg::ERASED;
      endcase
    end

    // Program memory read; fetches never see the overlay
    if (i_pm_rd) begin
      ovl_hit = i_page_sel[mem_decode_pkg::OVL_BIT] &&
                (i_pm_addr >= mem_decode_pkg::INFO_BASE) &&
                (i_pm_kind != mem_decode_pkg::PM_FETCH);
      next_state.pm_pend   = 1'b1;
      next_state.pm_region = pm_region(i_pm_addr);
      if (ovl_hit) begin
        next_state.pm_src   = mem_decode_pkg::PS_INFO;
        next_state.info_off = i_pm_addr[8:0];
      end else if (i_pm_addr <= mem_decode_pkg::FLASH_LAST) begin
        next_state.pm_src     = mem_decode_pkg::PS_FLASH;
        next_state.flash_re   = 1'b1;
        next_state.flash_addr = i_pm_addr[13:0];
      end else begin
        next_state.pm_src = mem_decode_pkg::PS_ERASED;
      end
    end

    // Only implemented flash takes a write; overlay and holes ignore it
    if (i_pm_wr && i_pm_addr <= mem_decode_pkg::FLASH_LAST) begin
      next_state.flash_we    = 1'b1;
      next_state.flash_addr  = i_pm_addr[13:0];
      next_state.flash_wdata = i_pm_wdata;
    end

    // No data memory behind the data space; requests are acknowledged empty
    next_state.dm_ack   = i_dm_req;
    next_state.dm_rdata = mem_decode_pkg::UNDEF;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // Outputs
  assign o_reg_ack     = state.reg_ack;
  assign o_reg_rdata   = state.reg_rdata;
  assign o_ram_re      = state.ram_re;
  assign o_ram_raddr   = state.ram_raddr;
  assign o_ram_we      = state.ram_we;
  assign o_ram_waddr   = state.ram_waddr;
  assign o_ram_wdata   = state.ram_wdata;
  assign o_tmr_re      = state.tmr_re;
  assign o_tmr_we      = state.tmr_we;
  assign o_pwm_re      = state.pwm_re;
  assign o_pwm_we      = state.pwm_we;
  assign o_per_re      = state.per_re;
  assign o_per_we      = state.per_we;
  assign o_ctl_raddr   = state.ctl_raddr;
  assign o_ctl_waddr   = state.ctl_waddr;
  assign o_ctl_wdata   = state.ctl_wdata;
  assign o_pm_ack      = state.pm_ack;
  assign o_pm_rdata    = state.pm_rdata;
  assign o_pm_region   = state.pm_region;
  assign o_flash_re    = state.flash_re;
  assign o_flash_we    = state.flash_we;
  assign o_flash_addr  = state.flash_addr;
  assign o_flash_wdata = state.flash_wdata;
  assign o_dm_ack      = state.dm_ack;
  assign o_dm_rdata    = state.dm_rdata;
  assign o_ovl_en      = state.ovl_en;

  // ==========================================================================
  // Checks
  ram_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_dst_wr && i_dst_addr <= mem_decode_pkg::RAM_LAST
    |=> o_ram_we && o_ram_waddr == $past(i_dst_addr[8:0]))
    else $error("RAM write not issued");

  ctl_region_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_src_rd && i_src_addr >= mem_decode_pkg::CTL_BASE
    |=> !o_ram_re && o_ctl_raddr == $past(i_src_addr[7:0]))
    else $error("Control read misrouted");

  hole_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_src_rd && i_src_addr > mem_decode_pkg::TMR_LAST && i_src_addr <= mem_decode_pkg::GAP_LAST
    |=> !o_tmr_re && !o_pwm_re && !o_per_re ##1 o_reg_ack)
    else $error("Unassigned read did not complete");

  gap_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_dst_wr && i_dst_addr > mem_decode_pkg::RAM_LAST && i_dst_addr < mem_decode_pkg::CTL_BASE
    |=> !o_ram_we && !o_tmr_we && !o_pwm_we && !o_per_we)
    else $error("Gap write reached a target");

  src_dst_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_src_rd && i_dst_wr && i_src_addr <= mem_decode_pkg::RAM_LAST
    && i_dst_addr <= mem_decode_pkg::RAM_LAST
    |=> o_ram_re && o_ram_we ##1 o_reg_ack && o_reg_rdata == $past(i_ram_rdata))
    else $error("Operand read or write lost");

  erased_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_pm_rd && i_pm_addr > mem_decode_pkg::FLASH_LAST
    && !(i_page_sel[7] && i_pm_kind != mem_decode_pkg::PM_FETCH)
    |-> ##2 o_pm_ack && o_pm_rdata == mem_decode_pkg::ERASED)
    else $error("Unimplemented read not FFh");

  pm_write_drop_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_pm_wr && i_pm_addr > mem_decode_pkg::FLASH_LAST |=> !o_flash_we)
    else $error("Write reached missing flash");

  vector_map_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_pm_rd && i_pm_addr > mem_decode_pkg::OPT_LAST && i_pm_addr <= mem_decode_pkg::RVEC_LAST
    |=> o_pm_region == mem_decode_pkg::PR_RESET_VEC)
    else $error("Reset vector region wrong");

  no_data_mem_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_dm_req && !i_src_rd && !i_pm_rd
    |=> o_dm_ack && !o_ram_re && !o_flash_re)
    else $error("Data request touched memory");

  overlay_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_pm_rd && i_page_sel[7] && i_pm_addr >= mem_decode_pkg::INFO_BASE
    && i_pm_kind != mem_decode_pkg::PM_FETCH
    |=> !o_flash_re && o_ovl_en ##1 o_pm_ack && o_pm_rdata == $past(info.data))
    else $error("Overlay read not from information area");

  fetch_flash_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_pm_rd && i_pm_kind == mem_decode_pkg::PM_FETCH && i_pm_addr <= mem_decode_pkg::FLASH_LAST
    |=> o_flash_re && o_flash_addr == $past(i_pm_addr[13:0]))
    else $error("Fetch not served by flash");

endmodule

//--- sim/mem_far_side.sv
// Behavioural memories and peripherals answering the decoder strobes
`timescale 1ns/1ps
module mem_far_side (
  input  wire logic        i_ram_re,
  input  wire logic [8:0]  i_ram_raddr,
  input  wire logic        i_tmr_re,
  input  wire logic        i_pwm_re,
  input  wire logic        i_per_re,
  input  wire logic        i_flash_re,
  input  wire logic [13:0] i_flash_addr,
  output logic [7:0]       o_ram_rdata,
  output logic [7:0]       o_tmr_rdata,
  output logic [7:0]       o_pwm_rdata,
  output logic [7:0]       o_per_rdata,
  output logic [7:0]       o_flash_rdata
);
  // Unselected parts show inverted bytes, so a stale capture never matches
  assign o_ram_rdata   = {8{~i_ram_re}} ^ i_ram_raddr[7:0] ^ 8'ha5;
  assign o_tmr_rdata   = {8{~i_tmr_re}} ^ 8'h11;
  assign o_pwm_rdata   = {8{~i_pwm_re}} ^ 8'h22;
  assign o_per_rdata   = {8{~i_per_re}} ^ 8'h33;
  assign o_flash_rdata = {8{~i_flash_re}} ^ i_flash_addr[7:0] ^ 8'h3c;
endmodule

//--- sim/test_memory_address_decoder.sv
// Self-checking bench for the memory address decoder
`timescale 1ns/1ps
module test_memory_address_decoder;
  logic        clk, rst, src_rd, dst_wr, pm_rd, pm_wr, dm_req, reg_ack, pm_ack, dm_ack, ovl;
  logic        ram_re, ram_we, tmr_re, tmr_we, pwm_re, pwm_we, per_re, per_we, fl_re, fl_we;
  logic [7:0]  page, wd, pm_wd, ram_d, tmr_d, pwm_d, per_d, fl_d, rdata, pm_rdata, dm_rdata;
  logic [7:0]  ctl_ra, ctl_wa, ctl_wd, ram_wd, fl_wd;
  logic [11:0] src_a, dst_a;
  logic [15:0] pm_a;
  logic [8:0]  ram_ra, ram_wa;
  logic [13:0] fl_a;
  mem_decode_pkg::pm_kind_e   kind;
  mem_decode_pkg::pm_region_e region;
  int          bad_count = 0;
  int          check_count = 0;
  int          cyc = 0;

  memory_address_decoder i_memory_address_decoder (.i_clk(clk), .i_rst(rst), .i_page_sel(page),
    .i_src_rd(src_rd), .i_src_addr(src_a), .i_dst_wr(dst_wr), .i_dst_addr(dst_a),
    .i_dst_wdata(wd), .o_reg_ack(reg_ack), .o_reg_rdata(rdata), .o_ram_re(ram_re),
    .o_ram_raddr(ram_ra), .o_ram_we(ram_we), .o_ram_waddr(ram_wa), .o_ram_wdata(ram_wd),
    .i_ram_rdata(ram_d), .o_tmr_re(tmr_re), .o_tmr_we(tmr_we), .o_pwm_re(pwm_re),
    .o_pwm_we(pwm_we), .o_per_re(per_re), .o_per_we(per_we), .o_ctl_raddr(ctl_ra),
    .o_ctl_waddr(ctl_wa), .o_ctl_wdata(ctl_wd), .i_tmr_rdata(tmr_d), .i_pwm_rdata(pwm_d),
    .i_per_rdata(per_d), .i_pm_rd(pm_rd), .i_pm_wr(pm_wr), .i_pm_kind(kind),
    .i_pm_addr(pm_a), .i_pm_wdata(pm_wd), .o_pm_ack(pm_ack), .o_pm_rdata(pm_rdata),
    .o_pm_region(region), .o_flash_re(fl_re), .o_flash_we(fl_we), .o_flash_addr(fl_a),
    .o_flash_wdata(fl_wd), .i_flash_rdata(fl_d), .i_dm_req(dm_req), .o_dm_ack(dm_ack),
    .o_dm_rdata(dm_rdata), .o_ovl_en(ovl));
  mem_far_side i_mem_far_side (.i_ram_re(ram_re), .i_ram_raddr(ram_ra), .i_tmr_re(tmr_re),
    .i_pwm_re(pwm_re), .i_per_re(per_re), .i_flash_re(fl_re), .i_flash_addr(fl_a),
    .o_ram_rdata(ram_d), .o_tmr_rdata(tmr_d), .o_pwm_rdata(pwm_d), .o_per_rdata(per_d),
    .o_flash_rdata(fl_d));

  // ==========================================================================
  // Helpers
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Strobe vector order: ram, timer, pwm, other
  task automatic rd(input logic [11:0] a, input logic [3:0] st, input logic [7:0] d);
    @(negedge clk);
    src_rd = 1;
    src_a = a;
    @(negedge clk);
    src_rd = 0;
    chk({reg_ack, ram_re, tmr_re, pwm_re, per_re}, {1'b0, st});
    if (st != 0) chk(st[3] ? ram_ra : ctl_ra, st[3] ? a[8:0] : a[7:0]);
    @(negedge clk);
    chk({reg_ack, rdata}, {1'b1, d});
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] st);
    @(negedge clk);
    dst_wr = 1;
    dst_a = a;
    wd = d;
    @(negedge clk);
    dst_wr = 0;
    chk({ram_we, tmr_we, pwm_we, per_we}, st);
    if (st[3]) chk({ram_wa, ram_wd}, {a[8:0], d});
    else if (st != 0) chk({ctl_wa, ctl_wd}, {a[7:0], d});
  endtask
  // Flash strobe x means not judged; region 7 means not judged
  task automatic pr(input mem_decode_pkg::pm_kind_e k, input logic [15:0] a,
                    input logic fre, input logic [7:0] d, input logic [2:0] rg);
    @(negedge clk);
    pm_rd = 1;
    kind = k;
    pm_a = a;
    @(negedge clk);
    pm_rd = 0;
    chk({pm_ack, ovl}, {1'b0, page[7]});
    if (fre !== 1'bx) chk(fl_re, fre);
    if (fre === 1'b1) chk(fl_a, a[13:0]);
    @(negedge clk);
    chk({pm_ack, pm_rdata}, {1'b1, d});
    if (rg != 3'h7) chk(region, rg);
  endtask
  task automatic pw(input logic [15:0] a, input logic [7:0] d, input logic fwe);
    @(negedge clk);
    pm_wr = 1;
    pm_a = a;
    pm_wd = d;
    @(negedge clk);
    pm_wr = 0;
    chk(fl_we, fwe);
    if (fwe) chk({fl_a, fl_wd}, {a[13:0], d});
  endtask

  // ==========================================================================
  // Scenarios
  task automatic test_reg_reads;
    logic [11:0] hole[4] = '{12'h200, 12'heff, 12'hf0a, 12'hf1f};
    rd(12'h000, 4'b1000, 8'ha5);
    rd(12'h1ff, 4'b1000, 8'h5a);
    foreach (hole[i]) rd(hole[i], 4'b0000, mem_decode_pkg::UNDEF);
    rd(12'hf00, 4'b0100, 8'h11);
    rd(12'hf09, 4'b0100, 8'h11);
    rd(12'hf20, 4'b0010, 8'h22);
    rd(12'hf29, 4'b0010, 8'h22);
    rd(12'hf2a, 4'b0001, 8'h33);
    rd(12'hfff, 4'b0001, 8'h33);
  endtask
  task automatic test_reg_writes;
    wr(12'h1ff, 8'h5a, 4'b1000);
    wr(12'h200, 8'h11, 4'b0000);
    wr(12'heff, 8'h22, 4'b0000);
    wr(12'hf05, 8'h33, 4'b0100);
    wr(12'hf15, 8'h44, 4'b0000);
    wr(12'hf21, 8'h5a, 4'b0010);
    wr(12'hfff, 8'h66, 4'b0001);
  endtask
  // Read and write in one cycle on independent ports
  task automatic test_src_dst;
    @(negedge clk);
    {src_rd, dst_wr, src_a, dst_a, wd} = {2'b11, 12'h010, 12'h020, 8'h77};
    @(negedge clk);
    {src_rd, dst_wr} = 2'b00;
    chk({ram_re, ram_we, ram_ra, ram_wa}, {2'b11, 9'h010, 9'h020});
    @(negedge clk);
    chk({reg_ack, rdata}, {1'b1, 8'hb5});
  endtask
  task automatic test_pm_map;
    logic [15:0] a[7] = '{16'h0000, 16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h0040, 16'h3fff};
    logic [2:0]  r[7] = '{1, 1, 2, 3, 4, 5, 5};
    mem_decode_pkg::pm_kind_e load_c = mem_decode_pkg::PM_PROGRAM_LOAD_CONSTANT_INSTR;
    for (int i = 0; i < 7; i++) begin
      pr(mem_decode_pkg::PM_FETCH, a[i], 1, a[i][7:0] ^ 8'h3c, r[i]);
    end
    pr(load_c, 16'h4000, 0, mem_decode_pkg::ERASED, 7);
  endtask
  task automatic test_overlay;
    mem_decode_pkg::pm_kind_e load_c = mem_decode_pkg::PM_PROGRAM_LOAD_CONSTANT_INSTR;
    mem_decode_pkg::pm_kind_e load_ci = mem_decode_pkg::PM_PROGRAM_LOAD_CONSTANT_INCR_INSTR;
    page = 8'h80;
    pr(load_c, 16'hfe40, 0, 8'h47, 7);
    pr(load_ci, 16'hfe41, 0, 8'h45, 7);
    pr(mem_decode_pkg::PM_DEBUG, 16'hfe50, 0, 8'h55, 7);
    pr(mem_decode_pkg::PM_DEBUG, 16'hfe5f, 0, mem_decode_pkg::PAD, 7);
    pr(load_c, 16'hfe00, 0, mem_decode_pkg::INFO_RSVD, 7);
    pr(load_c, 16'hfdff, 1'bx, mem_decode_pkg::ERASED, 7);
    pr(mem_decode_pkg::PM_FETCH, 16'hfe40, 1'bx, mem_decode_pkg::ERASED, 7);
    pw(16'hfe40, 8'h00, 0);
    pr(load_c, 16'hfe40, 0, 8'h47, 7);
    page = 8'h7f;
    pr(load_c, 16'hfe40, 1'bx, mem_decode_pkg::ERASED, 7);
  endtask
  task automatic test_misc;
    pw(16'h0100, 8'h33, 1);
    pw(16'h4000, 8'h44, 0);
    @(negedge clk);
    dm_req = 1;
    @(negedge clk);
    dm_req = 0;
    chk({dm_ack, dm_rdata, fl_re, ram_re}, {1'b1, 8'h00, 2'b00});
  endtask

  // ==========================================================================
  // Clock, reset, sequence
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    // Run needs about 130 cycles
    if (cyc == 2000) begin
      bad_count++;
      stop_test();
    end
  end
  initial begin
    {rst, src_rd, dst_wr, pm_rd, pm_wr, dm_req} = 6'b10_0000;
    {page, wd, pm_wd, src_a, dst_a, pm_a} = '0;
    kind = mem_decode_pkg::PM_FETCH;
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst = 0;
    chk({reg_ack, pm_ack, dm_ack, fl_re, fl_we, ovl}, 6'h00);
    test_reg_reads();
    test_reg_writes();
    test_src_dst();
    test_pm_map();
    test_overlay();
    test_misc();
    stop_test();
  end
endmodule
